// file: include/uad_pkg.sv
// Constants and types shared by the unified address decoder files
package uad_pkg;
	localparam int ADDR_W = 24;
	localparam logic [23:0] NVM_BASE = 24'h000000;
	localparam logic [23:0] RAM_TOP = 24'hffbfff;
	localparam logic [23:0] IO_BASE = 24'hffe000;
	localparam int IO_BYTES = 8192;
	localparam logic [23:0] CTL_TOP = 24'hffe01f;
	localparam logic [23:0] OPT_BASE = 24'h000000;
	localparam logic [23:0] RST_VEC = 24'h000004;
	localparam logic [23:0] SYSEXC_VEC = 24'h000008;
	localparam logic [23:0] TRAP_VEC = 24'h00000c;
	localparam logic [23:0] IRQ_VEC = 24'h000010;
	localparam logic [23:0] IRQ_VEC_TOP = 24'h00006f;
	localparam logic [23:0] PCLIM_ADDR = 24'hffe004;
	localparam logic [23:0] SPLIM_ADDR = 24'hffe00c;
	localparam logic [23:0] FLAGS_ADDR = 24'hffe010;
	localparam logic [23:0] PCTL_ADDR = 24'hffe012;
	localparam logic [31:0] PCLIM_RST = 32'h00ffffff;
	localparam logic [31:0] SPLIM_RST = 32'h00000000;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] PCTL_RST = 8'h00;
	localparam logic [7:0] UNPOP_BYTE = 8'hff;
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_QUAD = 2'h2;

	typedef enum logic [1:0] {RG_NVM, RG_RAM, RG_IO, RG_EXT} region_e;
	typedef enum logic [2:0] {AR_OPT, AR_RESET, AR_SYSEXC, AR_TRAP, AR_IRQ, AR_CODE} area_e;

	// Unknown size code is served as a byte
	function automatic logic [2:0] bytesOf(input logic [1:0] size);
		bytesOf = (size == SZ_QUAD) ? 3'h4 : (size == SZ_WORD) ? 3'h2 : 3'h1;
	endfunction
endpackage

// file: verilog/access_splitter.sv
// Splits one byte, word or quad transfer into 8/16-bit memory accesses
`timescale 1ns/1ns
module access_splitter (
	input wire logic clk,
	input wire logic srst,
	input wire logic start,
	input wire logic [23:0] startAddr,
	input wire logic [1:0] startSize,
	input wire logic startWrite,
	input wire logic [31:0] startWdata,
	input wire logic wide,
	input wire logic accDone,
	input wire logic [15:0] accRdata,
	output logic busy,
	output logic [23:0] accAddr,
	output logic [1:0] accBe,
	output logic [15:0] accWdata,
	output logic accWrite,
	output logic done,
	output logic [31:0] rdata
);
	logic busy_ff;
	logic [23:0] addr_ff;
	logic [2:0] remain_ff;
	logic write_ff;
	logic [31:0] wdata_ff;
	logic [31:0] rdata_ff;
	logic done_ff;
	logic take2;
	logic [2:0] step;
	logic [7:0] curByte;
	logic [7:0] nextByte;

	function automatic logic [7:0] byteAt(input logic [31:0] d, input logic [2:0] pos);
		byteAt = d[{pos[1:0], 3'h0} +: 8];
	endfunction

	// Pairs only on an even address of a 16-bit target
	assign take2 = wide && !addr_ff[0] && (remain_ff > 3'h1);
	assign step = take2 ? 3'h2 : 3'h1;
	// Remaining count picks the byte: most significant goes first
	assign curByte = byteAt(wdata_ff, remain_ff - 3'h1);
	assign nextByte = byteAt(wdata_ff, remain_ff - 3'h2);
	assign busy = busy_ff;
	assign accAddr = addr_ff;
	assign accWrite = write_ff;
	assign done = done_ff;
	assign rdata = rdata_ff;
	// Even byte on the high lane of a 16-bit target
	assign accBe = !wide ? 2'b01 : take2 ? 2'b11 : addr_ff[0] ? 2'b01 : 2'b10;
	assign accWdata = take2 ? {curByte, nextByte} :
		(wide && !addr_ff[0]) ? {curByte, 8'h00} : {8'h00, curByte};

	always_ff @(posedge clk) begin
		if (srst) begin
			busy_ff <= 1'b0;
			addr_ff <= 24'h000000;
			remain_ff <= 3'h0;
			write_ff <= 1'b0;
			wdata_ff <= 32'h00000000;
		end else if (start && !busy_ff) begin
			busy_ff <= 1'b1;
			addr_ff <= startAddr;
			remain_ff <= uad_pkg::bytesOf(startSize);
			write_ff <= startWrite;
			wdata_ff <= startWdata;
		end else if (busy_ff && accDone) begin
			// Ascending addresses, 24-bit wrap
			addr_ff <= addr_ff + {21'h000000, step};
			remain_ff <= remain_ff - step;
			if (remain_ff == step) begin
				busy_ff <= 1'b0;
			end
		end
	end

	// Bytes arrive MSB first, so shifting left right-aligns the result
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_ff <= 32'h00000000;
			done_ff <= 1'b0;
		end else begin
			done_ff <= busy_ff && accDone && (remain_ff == step);
			if (start && !busy_ff) begin
				rdata_ff <= 32'h00000000;
			end else if (busy_ff && accDone) begin
				if (take2) begin
					rdata_ff <= {rdata_ff[15:0], accRdata};
				end else if (wide && !addr_ff[0]) begin
					rdata_ff <= {rdata_ff[23:0], accRdata[15:8]};
				end else begin
					rdata_ff <= {rdata_ff[23:0], accRdata[7:0]};
				end
			end
		end
	end

	AST_EVEN_WORD_ONE: assert property (@(posedge clk) disable iff (srst)
		busy_ff && wide && !addr_ff[0] && remain_ff == 3'h2 && accDone |=> !busy_ff && done_ff)
		else $error("Even word on 16-bit target took more than one access");
	AST_ODD_SPLIT: assert property (@(posedge clk) disable iff (srst)
		busy_ff && wide && addr_ff[0] && remain_ff > 3'h1 && accDone |=> busy_ff && !done_ff)
		else $error("Odd multi-byte transfer ended after one access");
	AST_NARROW_BYTE: assert property (@(posedge clk) disable iff (srst)
		busy_ff && !wide |-> accBe == 2'b01)
		else $error("8-bit target given more than one byte lane");
	AST_ASCEND: assert property (@(posedge clk) disable iff (srst)
		busy_ff && accDone && remain_ff > step |=> accAddr == $past(addr_ff) + {21'h0, $past(step)})
		else $error("Next access address not ascending by step");
	AST_QUAD_MSB: assert property (@(posedge clk) disable iff (srst)
		busy_ff && !wide && remain_ff == 3'h4 |-> accWdata[7:0] == wdata_ff[31:24])
		else $error("First byte of quad is not the most significant");
	COV_ODD_QUAD: cover property (@(posedge clk) disable iff (srst)
		busy_ff && wide && addr_ff[0] && remain_ff == 3'h4);
endmodule

// file: verilog/cpu_control_regs.sv
// Processor control registers held at the bottom of the I/O region
`timescale 1ns/1ns
module cpu_control_regs (
	input wire logic clk,
	input wire logic srst,
	input wire logic sel,
	input wire logic write,
	input wire logic [23:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	output logic present,
	output logic [31:0] programCounterLimit,
	output logic [31:0] stackPointerLimit,
	output logic [7:0] flags,
	output logic [7:0] processorControl
);
	logic [31:0] pcLimit_ff;
	logic [31:0] spLimit_ff;
	logic [7:0] flags_ff;
	logic [7:0] pctl_ff;
	logic pcHit;
	logic spHit;
	logic [4:0] lane;

	// Lowest address holds the most significant byte
	assign pcHit = addr[23:2] == uad_pkg::PCLIM_ADDR[23:2];
	assign spHit = addr[23:2] == uad_pkg::SPLIM_ADDR[23:2];
	assign lane = {~addr[1:0], 3'h0};
	assign present = pcHit || spHit || addr == uad_pkg::FLAGS_ADDR || addr == uad_pkg::PCTL_ADDR;
	assign rdata = pcHit ? pcLimit_ff[lane +: 8] : spHit ? spLimit_ff[lane +: 8] :
		(addr == uad_pkg::FLAGS_ADDR) ? flags_ff : pctl_ff;
	assign programCounterLimit = pcLimit_ff;
	assign stackPointerLimit = spLimit_ff;
	assign flags = flags_ff;
	assign processorControl = pctl_ff;

	always_ff @(posedge clk) begin
		if (srst) begin
			pcLimit_ff <= uad_pkg::PCLIM_RST;
			spLimit_ff <= uad_pkg::SPLIM_RST;
			flags_ff <= uad_pkg::FLAGS_RST;
			pctl_ff <= uad_pkg::PCTL_RST;
		end else if (sel && write) begin
			if (pcHit) begin
				pcLimit_ff[lane +: 8] <= wdata;
			end else if (spHit) begin
				spLimit_ff[lane +: 8] <= wdata;
			end else if (addr == uad_pkg::FLAGS_ADDR) begin
				flags_ff <= wdata;
			end else if (addr == uad_pkg::PCTL_ADDR) begin
				pctl_ff <= wdata;
			end
		end
	end
endmodule

// file: verilog/unified_address_decoder.sv
// Unified 24-bit address decoder with two independent request ports
//
// Contract
// - One flat 24-bit, 16 MB byte space.
// - Two regions served concurrently, independent paths.
// - Byte, word and quad transfer sizes.
// - Nonvolatile memory decoded upward from zero.
// - Low nonvolatile block: options, vectors, interrupts.
// - RAM ends at FF_BFFF, size sets start.
// - 8 KB I/O region FF_E000 to FF_FFFF.
// - Unpopulated I/O reads return FF bytes.
// - Unpopulated I/O writes are discarded.
// - Everything unclaimed goes to external bus.
// - Big-endian: addressed byte is most significant.
// - Nonvolatile and RAM use 16-bit paths.
// - I/O serves 8-bit and 16-bit targets.
// - External bus width selectable, 8 or 16.
// - 16-bit even: word one, quad two accesses.
// - 16-bit odd: word two, quad three accesses.
// - Processor control registers at I/O bottom.
`timescale 1ns/1ns
module unified_address_decoder #(
	parameter logic [23:0] NVM_SIZE = 24'h020000,
	parameter logic [23:0] RAM_SIZE = 24'h004000
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic aReqValid,
	output logic aReqReady,
	input wire logic [23:0] aReqAddr,
	input wire logic [1:0] aReqSize,
	input wire logic aReqWrite,
	input wire logic [31:0] aReqWdata,
	output logic aRspValid,
	output logic [31:0] aRspRdata,
	input wire logic bReqValid,
	output logic bReqReady,
	input wire logic [23:0] bReqAddr,
	input wire logic [1:0] bReqSize,
	input wire logic bReqWrite,
	input wire logic [31:0] bReqWdata,
	output logic bRspValid,
	output logic [31:0] bRspRdata,
	output logic nvmReq,
	output logic [23:0] nvmAddr,
	output logic nvmWrite,
	output logic [1:0] nvmBe,
	output logic [15:0] nvmWdata,
	output logic [2:0] nvmArea,
	input wire logic nvmAck,
	input wire logic [15:0] nvmRdata,
	output logic ramReq,
	output logic [23:0] ramAddr,
	output logic ramWrite,
	output logic [1:0] ramBe,
	output logic [15:0] ramWdata,
	input wire logic ramAck,
	input wire logic [15:0] ramRdata,
	output logic ioReq,
	output logic [23:0] ioAddr,
	output logic ioWrite,
	output logic [1:0] ioBe,
	output logic [15:0] ioWdata,
	input wire logic ioPresent,
	input wire logic ioWide,
	input wire logic ioAck,
	input wire logic [15:0] ioRdata,
	input wire logic extWide,
	output logic extReq,
	output logic [23:0] extAddr,
	output logic extWrite,
	output logic [1:0] extBe,
	output logic [15:0] extWdata,
	input wire logic extAck,
	input wire logic [15:0] extRdata,
	output logic [31:0] programCounterLimit,
	output logic [31:0] stackPointerLimit,
	output logic [7:0] flags,
	output logic [7:0] processorControl
);
	localparam logic [23:0] RAM_BASE = uad_pkg::RAM_TOP - RAM_SIZE + 24'h000001;

	// RAM must fit below its fixed top and above the nonvolatile block
	if (RAM_SIZE == 24'h000000 || RAM_SIZE > uad_pkg::RAM_TOP || NVM_SIZE > RAM_BASE) begin : g_bad
		$error("RAM_SIZE and NVM_SIZE overlap or do not fit the map");
	end

	logic aBusy;
	logic [23:0] aAddr;
	logic [1:0] aBe;
	logic [15:0] aWdata;
	logic aWrite;
	logic aWide;
	logic aAck;
	logic [15:0] aRd;
	logic bBusy;
	logic [23:0] bAddr;
	logic [1:0] bBe;
	logic [15:0] bWdata;
	logic bWrite;
	logic bWide;
	logic bAck;
	logic [15:0] bRd;
	uad_pkg::region_e aReg;
	uad_pkg::region_e bReg;
	logic aGo;
	logic bGo;
	logic [3:0] onA;
	logic [3:0] onB;
	logic [3:0] ackVec;
	logic [15:0] rdVec [4];
	logic ioOn;
	logic ioInCtl;
	logic ioLocal;
	logic ioPathWide;
	logic [15:0] ioRdSel;
	logic [7:0] ctlRd;
	logic ctlHit;

	// Fixed I/O top, fixed RAM top, nonvolatile from zero, rest external
	function automatic uad_pkg::region_e regionOf(input logic [23:0] a);
		if (a >= uad_pkg::IO_BASE) begin
			regionOf = uad_pkg::RG_IO;
		end else if (a >= RAM_BASE && a <= uad_pkg::RAM_TOP) begin
			regionOf = uad_pkg::RG_RAM;
		end else if (a < uad_pkg::NVM_BASE + NVM_SIZE) begin
			regionOf = uad_pkg::RG_NVM;
		end else begin
			regionOf = uad_pkg::RG_EXT;
		end
	endfunction

	// Data path width of the target behind each region
	function automatic logic wideOf(input uad_pkg::region_e r, input logic ext, input logic io);
		case (r)
			uad_pkg::RG_NVM: wideOf = 1'b1;
			uad_pkg::RG_RAM: wideOf = 1'b1;
			uad_pkg::RG_IO: wideOf = io;
			uad_pkg::RG_EXT: wideOf = ext;
			default: wideOf = 1'b0;
		endcase
	endfunction

	function automatic uad_pkg::area_e areaOf(input logic [23:0] a);
		if (a < uad_pkg::RST_VEC) begin
			areaOf = uad_pkg::AR_OPT;
		end else if (a < uad_pkg::SYSEXC_VEC) begin
			areaOf = uad_pkg::AR_RESET;
		end else if (a < uad_pkg::TRAP_VEC) begin
			areaOf = uad_pkg::AR_SYSEXC;
		end else if (a < uad_pkg::IRQ_VEC) begin
			areaOf = uad_pkg::AR_TRAP;
		end else if (a <= uad_pkg::IRQ_VEC_TOP) begin
			areaOf = uad_pkg::AR_IRQ;
		end else begin
			areaOf = uad_pkg::AR_CODE;
		end
	endfunction

	access_splitter u_splitA (
		.clk(clk),
		.srst(srst),
		.start(aReqValid),
		.startAddr(aReqAddr),
		.startSize(aReqSize),
		.startWrite(aReqWrite),
		.startWdata(aReqWdata),
		.wide(aWide),
		.accDone(aAck),
		.accRdata(aRd),
		.busy(aBusy),
		.accAddr(aAddr),
		.accBe(aBe),
		.accWdata(aWdata),
		.accWrite(aWrite),
		.done(aRspValid),
		.rdata(aRspRdata)
	);

	access_splitter u_splitB (
		.clk(clk),
		.srst(srst),
		.start(bReqValid),
		.startAddr(bReqAddr),
		.startSize(bReqSize),
		.startWrite(bReqWrite),
		.startWdata(bReqWdata),
		.wide(bWide),
		.accDone(bAck),
		.accRdata(bRd),
		.busy(bBusy),
		.accAddr(bAddr),
		.accBe(bBe),
		.accWdata(bWdata),
		.accWrite(bWrite),
		.done(bRspValid),
		.rdata(bRspRdata)
	);

	cpu_control_regs u_ctl (
		.clk(clk),
		.srst(srst),
		.sel(ioOn && ioInCtl),
		.write(ioWrite),
		.addr(ioAddr),
		.wdata(ioWdata[7:0]),
		.rdata(ctlRd),
		.present(ctlHit),
		.programCounterLimit(programCounterLimit),
		.stackPointerLimit(stackPointerLimit),
		.flags(flags),
		.processorControl(processorControl)
	);

	assign aReqReady = !aBusy;
	assign bReqReady = !bBusy;
	// Each access is decoded on its own address, so a transfer may cross regions
	assign aReg = regionOf(aAddr);
	assign bReg = regionOf(bAddr);
	// Port A wins a shared region; different regions proceed together
	assign aGo = aBusy;
	assign bGo = bBusy && !(aBusy && aReg == bReg);

	always_comb begin
		for (int r = 0; r < 4; r++) begin
			onA[r] = aGo && (int'(aReg) == r);
			onB[r] = bGo && (int'(bReg) == r);
		end
	end

	assign nvmReq = onA[uad_pkg::RG_NVM] || onB[uad_pkg::RG_NVM];
	assign nvmAddr = onA[uad_pkg::RG_NVM] ? aAddr : bAddr;
	assign nvmWrite = nvmReq && (onA[uad_pkg::RG_NVM] ? aWrite : bWrite);
	assign nvmBe = onA[uad_pkg::RG_NVM] ? aBe : bBe;
	assign nvmWdata = onA[uad_pkg::RG_NVM] ? aWdata : bWdata;
	assign nvmArea = areaOf(nvmAddr);

	assign ramReq = onA[uad_pkg::RG_RAM] || onB[uad_pkg::RG_RAM];
	assign ramAddr = onA[uad_pkg::RG_RAM] ? aAddr : bAddr;
	assign ramWrite = ramReq && (onA[uad_pkg::RG_RAM] ? aWrite : bWrite);
	assign ramBe = onA[uad_pkg::RG_RAM] ? aBe : bBe;
	assign ramWdata = onA[uad_pkg::RG_RAM] ? aWdata : bWdata;

	assign extReq = onA[uad_pkg::RG_EXT] || onB[uad_pkg::RG_EXT];
	assign extAddr = onA[uad_pkg::RG_EXT] ? aAddr : bAddr;
	assign extWrite = extReq && (onA[uad_pkg::RG_EXT] ? aWrite : bWrite);
	assign extBe = onA[uad_pkg::RG_EXT] ? aBe : bBe;
	assign extWdata = onA[uad_pkg::RG_EXT] ? aWdata : bWdata;

	// Control window and unpopulated addresses are answered here, same cycle
	assign ioOn = onA[uad_pkg::RG_IO] || onB[uad_pkg::RG_IO];
	assign ioAddr = onA[uad_pkg::RG_IO] ? aAddr : bAddr;
	assign ioWrite = ioOn && (onA[uad_pkg::RG_IO] ? aWrite : bWrite);
	assign ioBe = onA[uad_pkg::RG_IO] ? aBe : bBe;
	assign ioWdata = onA[uad_pkg::RG_IO] ? aWdata : bWdata;
	assign ioInCtl = ioAddr <= uad_pkg::CTL_TOP;
	assign ioLocal = ioInCtl || !ioPresent;
	// A discarded write never reaches a peripheral
	assign ioReq = ioOn && !ioLocal;
	// Control registers and holes are byte targets
	assign ioPathWide = !ioLocal && ioWide;
	assign ioRdSel = (ioInCtl && ctlHit) ? {8'h00, ctlRd} :
		ioLocal ? {uad_pkg::UNPOP_BYTE, uad_pkg::UNPOP_BYTE} : ioRdata;

	assign aWide = wideOf(aReg, extWide, ioPathWide);
	assign bWide = wideOf(bReg, extWide, ioPathWide);

	// Missing external devices just ack with whatever is on the bus
	assign ackVec = {extAck, ioLocal || ioAck, ramAck, nvmAck};
	assign rdVec[uad_pkg::RG_NVM] = nvmRdata;
	assign rdVec[uad_pkg::RG_RAM] = ramRdata;
	assign rdVec[uad_pkg::RG_IO] = ioRdSel;
	assign rdVec[uad_pkg::RG_EXT] = extRdata;
	assign aAck = |(onA & ackVec);
	assign bAck = |(onB & ackVec);
	assign aRd = rdVec[aReg];
	assign bRd = rdVec[bReg];

	AST_ONE_OWNER: assert property (@(posedge clk) disable iff (srst)
		$onehot0(onA | onB) || (onA & onB) == 4'h0)
		else $error("Both ports drive the same region");
	AST_PARALLEL: assert property (@(posedge clk) disable iff (srst)
		aBusy && bBusy && aReg != bReg |-> onA != 4'h0 && onB != 4'h0)
		else $error("Port stalled although regions differ");
	AST_UNPOP_READ: assert property (@(posedge clk) disable iff (srst)
		ioOn && !ioInCtl && !ioPresent |-> !ioReq && ioRdSel == 16'hffff && ackVec[2])
		else $error("Unpopulated I/O read not answered with FF");
	AST_UNPOP_WRITE: assert property (@(posedge clk) disable iff (srst)
		ioOn && ioWrite && !ioInCtl && !ioPresent |=> $stable(programCounterLimit) && !$past(ioReq))
		else $error("Unpopulated I/O write reached a target");
	AST_IO_CLAIM: assert property (@(posedge clk) disable iff (srst)
		aBusy && aAddr >= 24'hffe000 |-> onA[uad_pkg::RG_IO] && !onA[uad_pkg::RG_EXT])
		else $error("I/O address not routed to I/O path");
	AST_RAM_TOP: assert property (@(posedge clk) disable iff (srst)
		aBusy && aAddr == 24'hffbfff |-> onA[uad_pkg::RG_RAM] && ramAddr == 24'hffbfff)
		else $error("Top of RAM not routed to RAM");
	COV_BOTH_PATHS: cover property (@(posedge clk) disable iff (srst)
		onA != 4'h0 && onB != 4'h0);
	COV_UNPOP_IO: cover property (@(posedge clk) disable iff (srst)
		ioOn && !ioInCtl && !ioPresent);
	COV_CTL_WRITE: cover property (@(posedge clk) disable iff (srst)
		ioOn && ioInCtl && ctlHit && ioWrite);
endmodule

// file: tb/mem_model.sv
// Behavioural 8/16-bit memory behind one access port of the decoder
`timescale 1ns/1ns
module mem_model (
	input wire logic clk,
	input wire logic req,
	input wire logic [23:0] addr,
	input wire logic write,
	input wire logic [1:0] be,
	input wire logic [15:0] wdata,
	input wire logic wide,
	input wire logic slow,
	output logic ack,
	output logic [15:0] rdata
);
	logic [7:0] mem [logic [23:0]];
	logic [1:0] waitCnt = 2'h0;
	logic [15:0] lastData = 16'h0000;
	logic [23:0] evenA;
	function automatic logic [7:0] rd(input logic [23:0] a);
		rd = mem.exists(a) ? mem[a] : a[7:0] ^ a[15:8] ^ 8'ha5;
	endfunction
	assign evenA = {addr[23:1], 1'b0};
	// Slow mode holds each access off for two cycles
	assign ack = req && (!slow || waitCnt == 2'h2);
	// Idle lines show the inverse so a stale value never matches
	assign rdata = !req ? ~lastData : wide ? {rd(evenA), rd(evenA + 24'h1)} :
		{~rd(addr), rd(addr)};
	always @(posedge clk) begin
		waitCnt <= (req && !ack) ? waitCnt + 2'h1 : 2'h0;
		if (ack) lastData <= rdata;
		if (ack && write && wide && be[1]) mem[evenA] = wdata[15:8];
		if (ack && write && wide && be[0]) mem[evenA + 24'h1] = wdata[7:0];
		if (ack && write && !wide) mem[addr] = wdata[7:0];
	end
endmodule

// file: tb/tb_unified_address_decoder.sv
// Self-checking bench for the unified address decoder
`timescale 1ns/1ns
module tb_unified_address_decoder;
	localparam logic [1:0] B = uad_pkg::SZ_BYTE;
	localparam logic [1:0] W = uad_pkg::SZ_WORD;
	localparam logic [1:0] Q = uad_pkg::SZ_QUAD;
	logic clk, srst, aReqValid, aReqReady, aReqWrite, aRspValid, slowMem, extWide;
	logic bReqValid, bReqReady, bReqWrite, bRspValid, ioPresent, ioWide;
	logic nvmReq, nvmWrite, nvmAck, ramReq, ramWrite, ramAck;
	logic ioReq, ioWrite, ioAck, extReq, extWrite, extAck;
	logic [23:0] aReqAddr, bReqAddr, nvmAddr, ramAddr, ioAddr, extAddr;
	logic [1:0] aReqSize, bReqSize, nvmBe, ramBe, ioBe, extBe;
	logic [31:0] aReqWdata, aRspRdata, bReqWdata, bRspRdata;
	logic [31:0] programCounterLimit, stackPointerLimit;
	logic [15:0] nvmWdata, nvmRdata, ramWdata, ramRdata, ioWdata, ioRdata, extWdata, extRdata;
	logic [2:0] nvmArea, lastArea;
	logic [7:0] flags, processorControl;
	int failures = 0, n_checks = 0, nBoth = 0;
	int nAcc [4];
	logic [23:0] extLog [$];

	unified_address_decoder #(.NVM_SIZE(24'h020000), .RAM_SIZE(24'h004000)) u_dut (
		.clk, .srst, .aReqValid, .aReqReady, .aReqAddr, .aReqSize, .aReqWrite, .aReqWdata,
		.aRspValid, .aRspRdata, .bReqValid, .bReqReady, .bReqAddr, .bReqSize, .bReqWrite,
		.bReqWdata, .bRspValid, .bRspRdata, .nvmReq, .nvmAddr, .nvmWrite, .nvmBe, .nvmWdata,
		.nvmArea, .nvmAck, .nvmRdata, .ramReq, .ramAddr, .ramWrite, .ramBe, .ramWdata, .ramAck,
		.ramRdata, .ioReq, .ioAddr, .ioWrite, .ioBe, .ioWdata, .ioPresent, .ioWide, .ioAck,
		.ioRdata, .extWide, .extReq, .extAddr, .extWrite, .extBe, .extWdata, .extAck,
		.extRdata, .programCounterLimit, .stackPointerLimit, .flags, .processorControl);
	// Peripherals decode FF_E100-FF_E1FF; upper half of it is 16-bit
	assign ioPresent = ioAddr[23:8] == 16'hffe1;
	assign ioWide = ioAddr[7];
	mem_model u_nvm (.clk, .req(nvmReq), .addr(nvmAddr), .write(nvmWrite), .be(nvmBe),
		.wdata(nvmWdata), .wide(1'b1), .slow(slowMem), .ack(nvmAck), .rdata(nvmRdata));
	mem_model u_ram (.clk, .req(ramReq), .addr(ramAddr), .write(ramWrite), .be(ramBe),
		.wdata(ramWdata), .wide(1'b1), .slow(slowMem), .ack(ramAck), .rdata(ramRdata));
	mem_model u_io (.clk, .req(ioReq), .addr(ioAddr), .write(ioWrite), .be(ioBe),
		.wdata(ioWdata), .wide(ioWide), .slow(slowMem), .ack(ioAck), .rdata(ioRdata));
	mem_model u_ext (.clk, .req(extReq), .addr(extAddr), .write(extWrite), .be(extBe),
		.wdata(extWdata), .wide(extWide), .slow(slowMem), .ack(extAck), .rdata(extRdata));

	always @(posedge clk) begin
		if (nvmReq && ramReq) nBoth++;
		if (nvmReq && nvmAck) nAcc[0]++;
		if (nvmReq && nvmAck) lastArea = nvmArea;
		if (ramReq && ramAck) nAcc[1]++;
		if (ioReq && ioAck) nAcc[2]++;
		if (extReq && extAck) nAcc[3]++;
		if (extReq && extAck) extLog.push_back(extAddr);
	end

	function automatic logic [7:0] a8(input logic [23:0] b);
		a8 = b[7:0] ^ b[15:8] ^ 8'ha5;
	endfunction
	function automatic logic [31:0] pat(input logic [23:0] a, input int sz);
		pat = 32'h0;
		for (int k = 0; k < (sz == 2 ? 4 : sz + 1); k++) pat = {pat[23:0], a8(a + 24'(k))};
	endfunction

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic xfer(input logic port, input logic [23:0] ad, input logic [1:0] sz,
		input logic wr, input logic [31:0] wd, output logic [31:0] rd);
		int i;
		for (i = 0; i < 60 && (port ? !bReqReady : !aReqReady); i++) @(negedge clk);
		if (i == 60) begin
			$display("MISMATCH ready expected 1 seen 0");
			failures++;
			tally_and_finish();
		end
		if (port) {bReqValid, bReqAddr, bReqSize, bReqWrite, bReqWdata} = {1'b1, ad, sz, wr, wd};
		else {aReqValid, aReqAddr, aReqSize, aReqWrite, aReqWdata} = {1'b1, ad, sz, wr, wd};
		@(negedge clk);
		if (port) bReqValid = 1'b0;
		else aReqValid = 1'b0;
		for (i = 0; i < 60 && !(port ? bRspValid : aRspValid); i++) @(negedge clk);
		rd = port ? bRspRdata : aRspRdata;
		if (i == 60) begin
			$display("MISMATCH response expected 1 seen 0");
			failures++;
			tally_and_finish();
		end
	endtask
	task automatic do_reset();
		srst = 1'b1;
		repeat (16) @(negedge clk);
		srst = 1'b0;
	endtask

	task automatic t_reset();
		chk("ready", 32'h1, {31'h0, aReqReady & bReqReady});
		chk("pc limit", uad_pkg::PCLIM_RST, programCounterLimit);
		chk("sp limit", uad_pkg::SPLIM_RST, stackPointerLimit);
		chk("flags", {24'h0, uad_pkg::FLAGS_RST}, {24'h0, flags});
		chk("proc ctl", {24'h0, uad_pkg::PCTL_RST}, {24'h0, processorControl});
		$display("test reset done");
	endtask
	task automatic t_map();
		logic [23:0] ad [12] = '{24'h000000, 24'h000005, 24'h00000b, 24'h00000c, 24'h00006f,
			24'h000070, 24'h01ffff, 24'h020000, 24'hff7fff, 24'hff8000, 24'hffbfff, 24'hffdfff};
		int rg [12] = '{0, 0, 0, 0, 0, 0, 0, 3, 3, 1, 1, 3};
		int ar [7] = '{0, 1, 2, 3, 4, 5, 5};
		logic [31:0] rd;
		for (int k = 0; k < 12; k++) begin
			nAcc = '{0, 0, 0, 0};
			xfer(k[0], ad[k], B, 1'b0, 32'h0, rd);
			chk("region hit", 32'h1, 32'(nAcc[rg[k]]));
			chk("byte data", pat(ad[k], 0), rd);
			if (k < 7) chk("nvm area", 32'(ar[k]), {29'h0, lastArea});
		end
		$display("test map done");
	endtask
	task automatic t_align();
		int expN [6] = '{1, 1, 1, 2, 2, 3};
		logic [23:0] a;
		logic [31:0] rd;
		slowMem = 1'b1;
		for (int k = 0; k < 6; k++) begin
			a = 24'h000100 + 24'(k % 2);
			nAcc = '{0, 0, 0, 0};
			xfer(1'b0, a, 2'(k / 2), 1'b0, 32'h0, rd);
			chk("nvm data", pat(a, k / 2), rd);
			chk("nvm accesses", 32'(expN[k]), 32'(nAcc[0]));
		end
		slowMem = 1'b0;
		$display("test align done");
	endtask
	task automatic t_io();
		logic [31:0] rd;
		nAcc = '{0, 0, 0, 0};
		xfer(1'b0, 24'hffe200, Q, 1'b0, 32'h0, rd);
		chk("unpopulated", 32'hffffffff, rd);
		xfer(1'b0, 24'hfffffe, W, 1'b1, 32'h1234, rd);
		xfer(1'b0, 24'hffe000, B, 1'b0, 32'h0, rd);
		chk("ctl hole", 32'h000000ff, rd);
		chk("io accesses", 32'h0, 32'(nAcc[2]));
		xfer(1'b0, 24'hffe100, W, 1'b0, 32'h0, rd);
		chk("narrow io", pat(24'hffe100, 1), rd);
		xfer(1'b0, 24'hffe181, Q, 1'b0, 32'h0, rd);
		chk("wide io", pat(24'hffe181, 2), rd);
		chk("io accesses", 32'd5, 32'(nAcc[2]));
		xfer(1'b0, uad_pkg::PCLIM_ADDR, Q, 1'b1, 32'h12345678, rd);
		xfer(1'b1, uad_pkg::SPLIM_ADDR, Q, 1'b1, 32'h9abcdef0, rd);
		xfer(1'b0, uad_pkg::FLAGS_ADDR, W, 1'b1, 32'h5a3c, rd);
		xfer(1'b0, uad_pkg::PCTL_ADDR, B, 1'b1, 32'hc3, rd);
		chk("pc limit", 32'h12345678, programCounterLimit);
		chk("sp limit", 32'h9abcdef0, stackPointerLimit);
		chk("flags", 32'h5a, {24'h0, flags});
		chk("proc ctl", 32'hc3, {24'h0, processorControl});
		// Flags and processor control are read back, with FF from the holes beside them
		xfer(1'b0, uad_pkg::FLAGS_ADDR, Q, 1'b0, 32'h0, rd);
		chk("ctl readback", 32'h5affc3ff, rd);
		$display("test io done");
	endtask
	task automatic t_ext();
		logic [31:0] rd;
		extWide = 1'b0;
		extLog.delete();
		xfer(1'b1, 24'h400001, Q, 1'b0, 32'h0, rd);
		chk("narrow ext", pat(24'h400001, 2), rd);
		chk("narrow count", 32'd4, 32'(extLog.size()));
		for (int k = 0; k < extLog.size(); k++) begin
			chk("ext order", 24'h400001 + 24'(k), {8'h0, extLog[k]});
		end
		xfer(1'b1, 24'h400010, Q, 1'b1, 32'ha1b2c3d4, rd);
		xfer(1'b0, 24'h400013, B, 1'b0, 32'h0, rd);
		chk("narrow write", 32'h000000d4, rd);
		extWide = 1'b1;
		extLog.delete();
		xfer(1'b1, 24'h400001, Q, 1'b0, 32'h0, rd);
		chk("wide count", 32'd3, 32'(extLog.size()));
		$display("test ext done");
	endtask
	task automatic t_par();
		logic [31:0] ra, rb;
		nBoth = 0;
		fork
			xfer(1'b0, 24'h000200, Q, 1'b0, 32'h0, ra);
			xfer(1'b1, 24'hff9001, Q, 1'b1, 32'h11223344, rb);
		join
		chk("parallel", 32'h1, 32'(nBoth > 0));
		chk("port a", pat(24'h000200, 2), ra);
		fork
			xfer(1'b0, 24'hff9000, Q, 1'b0, 32'h0, ra);
			xfer(1'b1, 24'hff9003, B, 1'b0, 32'h0, rb);
		join
		chk("odd write", {a8(24'hff9000), 24'h112233}, ra);
		chk("shared b", 32'h00000033, rb);
		$display("test parallel done");
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{aReqValid, aReqAddr, aReqSize, aReqWrite, aReqWdata} = '0;
		{bReqValid, bReqAddr, bReqSize, bReqWrite, bReqWdata} = '0;
		slowMem = 1'b0;
		extWide = 1'b1;
		srst = 1'b1;
		@(negedge clk);
		do_reset();
		t_reset();
		t_map();
		t_align();
		t_io();
		t_ext();
		t_par();
		// Reset in mid-run must restore the register values
		do_reset();
		t_reset();
		tally_and_finish();
	end
endmodule
